// File: rtl/hostreg_pkg.sv
// Purpose: Shared constants and carriers for the terminal host register bank.
// Assumes: 125 MHz clock; APB with 32-bit data, 16-bit registers in low bits.
// Notes: Register offsets are byte addresses on aligned words.
package hostreg_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CFG1 = 8'h00;
  localparam logic [7:0] OFF_CFG2 = 8'h04;
  localparam logic [7:0] OFF_START = 8'h08;
  localparam logic [7:0] OFF_CSTK = 8'h0C;
  localparam logic [7:0] OFF_ILP = 8'h10;
  localparam logic [7:0] OFF_CTLW = 8'h14;
  localparam logic [7:0] OFF_TTAG = 8'h18;
  localparam logic [7:0] OFF_ISR1 = 8'h1C;
  localparam logic [7:0] OFF_ISR2 = 8'h20;
  localparam logic [7:0] OFF_DSTK = 8'h24;
  localparam logic [7:0] OFF_FREM = 8'h28;
  localparam logic [7:0] OFF_MREM = 8'h2C;
  localparam logic [7:0] OFF_FTIME = 8'h30;
  localparam logic [7:0] OFF_IILP = 8'h34;
  localparam logic [7:0] OFF_CCODE = 8'h38;
  localparam logic [7:0] OFF_GPFLAG = 8'h3C;
  localparam logic [7:0] OFF_GPQ = 8'h40;
  localparam logic [7:0] OFF_ISQ = 8'h44;
  localparam logic [7:0] OFF_MASK1 = 8'h48;
  localparam logic [7:0] OFF_MASK2 = 8'h4C;
  localparam logic [7:0] OFF_CFG3 = 8'h50;
  localparam logic [7:0] OFF_CFG6 = 8'h54;
  // Start/reset command bits.
  localparam int CMD_SWRST = 0;
  localparam int CMD_START = 1;
  localparam int CMD_IRQRST = 2;
  localparam int CMD_TTRST = 3;
  localparam int CMD_TTTEST = 4;
  localparam int CMD_BIST = 5;
  localparam int CMD_BCLR = 6;
  localparam int CMD_HALTCLR = 7;
  localparam int CMD_STOPMSG = 8;
  localparam int CMD_STOPFRM = 9;
  // Configuration field positions and mode codes.
  localparam int CFG1_MODE_LO = 0;
  localparam int CFG1_ENH_BC = 2;
  localparam int CFG1_AUTORPT = 3;
  localparam int CFG2_LVLPULSE = 0;
  localparam int CFG2_RES_LO = 1;
  localparam int CFG3_TRIG_START = 0;
  localparam int CFG3_TRIG_STOP = 1;
  localparam int CFG3_TRIG_IRQ = 2;
  localparam int CFG6_ENH_ACCESS = 0;
  localparam int ISR2_CHAIN = 15;
  localparam int ISR1_TRIG = 0;
  localparam int GP_CLR_LO = 8;
  localparam logic [1:0] MODE_BC = 2'h0;
  localparam logic [1:0] MODE_RT = 2'h1;
  localparam logic [1:0] MODE_MSGMON = 2'h2;
  localparam logic [1:0] MODE_WORDMON = 2'h3;
  localparam logic [15:0] CFG6_RESET = 16'h0001;
  localparam logic [2:0] RES_MAX = 3'h5;
  // Timing.
  localparam int CLK_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int FRAME_LSB_US = 100;
  localparam int MSG_LSB_US = 1;

  // APB request and answer.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  // Reports from the protocol and sequencing engines.
  typedef struct packed {
    logic start_of_message_event;
    logic end_of_message_event;
    logic cstk_vld;
    logic [15:0] cstk;
    logic ilp_vld;
    logic [15:0] ilp;
    logic cw_vld;
    logic [15:0] cw;
    logic rtcmd_vld;
    logic [15:0] rtcmd;
    logic mword_vld;
    logic [15:0] mword;
    logic dstk_vld;
    logic [15:0] dstk;
    logic mrem_ld;
    logic [15:0] mrem;
    logic gpq_inc;
    logic isq_inc;
    logic [7:0] cc_result;
    logic [15:0] isr1_ev;
    logic [15:0] isr2_ev;
  } eng_s;

  // Controls toward the engines.
  typedef struct packed {
    logic sw_reset;
    logic bist_start;
    logic bist_clear;
    logic halt_clear;
    logic frame_start;
    logic bc_running;
    logic mon_running;
    logic trig_hit;
    logic msg_timer_zero;
    logic ttag_wr;
    logic [15:0] ttag_val;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg6;
    logic [15:0] init_ilp;
    logic [7:0] gp_flags;
    logic [15:0] gpq;
    logic [15:0] isq;
    logic [15:0] dstk;
  } ctl_s;
endpackage

// File: rtl/tick_gen.sv
// Purpose: Microsecond, 100 us and time tag tick generation.
// Assumes: Clock period divides one microsecond evenly.
// Notes: Time tag resolution codes above the largest clamp to it.
`timescale 1ns/1ps
module tick_gen #(
  parameter int CYC_PER_US = hostreg_pkg::CYC_PER_US,
  parameter int FRAME_US = hostreg_pkg::FRAME_LSB_US
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic sync_clr,
  input wire logic [2:0] res_sel,
  // Ticks.
  output logic us_tick,
  output logic frame_tick,
  output logic ttag_tick
);
  typedef struct packed {
    logic [7:0] pre;
    logic [6:0] hund;
    logic [5:0] tt;
    logic us;
    logic fr;
    logic ttk;
  } tk_s;
  tk_s r, n;
  logic [2:0] res;
  logic [5:0] msk;

  // Divides the clock down and flags the selected time tag period.
  always_comb begin
    n = r;
    n.us = 1'b0;
    n.fr = 1'b0;
    n.ttk = 1'b0;
    res = (res_sel > hostreg_pkg::RES_MAX) ? hostreg_pkg::RES_MAX : res_sel;
    msk = 6'(({1'b0, 6'h3F}) >> (hostreg_pkg::RES_MAX - res));
    if (r.pre == 8'(CYC_PER_US - 1)) begin
      n.pre = '0;
      n.us = 1'b1;
      n.hund = (r.hund == 7'(FRAME_US - 1)) ? '0 : r.hund + 7'h01;
      n.fr = (r.hund == 7'(FRAME_US - 1));
      n.tt = r.tt + 6'h01;
      n.ttk = ((r.tt & msk) == msk);
    end else begin
      n.pre = r.pre + 8'h01;
    end
    if (sync_clr) begin
      n.pre = '0;
      n.tt = '0;
      n.ttk = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign us_tick = r.us;
  assign frame_tick = r.fr;
  assign ttag_tick = r.ttk;
endmodule // tick_gen

// File: rtl/terminal_host_register_bank.sv
// Purpose: Host register bank of a 1553 controller/terminal/monitor core.
// Assumes: APB slave with no wait states; engines report through eng_s.
// Notes: Read data is captured in the setup cycle of a transfer.
`timescale 1ns/1ps
// Operation
// - Start/reset writes are one-shot commands.
// - Auto-repeat stops after message or frame.
// - Command stack reads current or last pointer.
// - Enhanced mode reads live instruction pointer.
// - Control word mirrors controller or subaddress word.
// - Time tag ticks every 2 to 64 us.
// - Time tag stored at message start, end, except in word monitor mode.
// - Status bits align with mask bit positions.
// - Second status holds chain flag for first.
// - Data stack address readable, writable, tracks engine.
// - Frame remaining counts down per 100 us.
// - Message remaining counts down per microsecond.
// - Controller mode: frame period, 100 us units.
// - Terminal mode: shared register captures command.
// - Word monitor: trigger word starts, stops, flags.
// - Reset clears config except enhanced access bit.
// - Host sets, clears or toggles general flags.
// - Condition code register returns engine flags.
// - Queue pointer: host loads, engine increments.
// - Status queue pointer: host loads, engine advances.
module terminal_host_register_bank #(
  parameter int CYC_PER_US = hostreg_pkg::CYC_PER_US
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus.
  input wire hostreg_pkg::apb_req_s apb_req,
  output hostreg_pkg::apb_rsp_s apb_rsp,
  // Engine side.
  input wire hostreg_pkg::eng_s eng,
  output hostreg_pkg::ctl_s ctl
);
  typedef enum logic [1:0] {BC_IDLE, BC_RUN, BC_STOP_MSG, BC_STOP_FRM} bc_state_e;

  typedef struct packed {
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg6;
    logic [15:0] mask1;
    logic [15:0] mask2;
    logic [15:0] isr1;
    logic [15:0] isr2;
    logic [15:0] cstk;
    logic [15:0] ilp;
    logic [15:0] ctlw;
    logic [15:0] ttag;
    logic [15:0] dstk;
    logic [15:0] frem;
    logic [15:0] mrem;
    logic [15:0] ftime;
    logic [15:0] iilp;
    logic [7:0] gp;
    logic [15:0] gpq;
    logic [15:0] isq;
    bc_state_e bc;
    logic mon;
    logic [31:0] prdata;
    logic pslverr;
    logic swrst_p;
    logic bist_p;
    logic bclr_p;
    logic halt_p;
    logic fstart_p;
    logic trig_p;
    logic tt_wr;
    logic [15:0] tt_val;
  } st_s;

  st_s r, n;
  logic setup;
  logic wr;
  logic [15:0] wd;
  logic [15:0] cmd;
  logic [1:0] mode;
  logic us_tick;
  logic frame_tick;
  logic ttag_tick;
  logic fend;
  logic hit;

  // Decode helper: is this access a write at the given offset.
  function automatic logic wr_at(input logic [7:0] off);
    wr_at = wr && (apb_req.paddr == off);
  endfunction

  // Bus phase decode; the slave never inserts wait states.
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wd = apb_req.pwdata[15:0];
  assign cmd = wr_at(hostreg_pkg::OFF_START) ? wd : 16'h0000;
  assign mode = r.cfg1[hostreg_pkg::CFG1_MODE_LO +: 2];
  assign fend = frame_tick && (r.bc != BC_IDLE) && (r.frem <= 16'h0001);
  assign hit = eng.mword_vld && (mode == hostreg_pkg::MODE_WORDMON) && (eng.mword == r.ftime);

  // Shared timebase for message timer, frame timer and time tag.
  tick_gen #(
    .CYC_PER_US(CYC_PER_US),
    .FRAME_US(hostreg_pkg::FRAME_LSB_US)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .sync_clr(cmd[hostreg_pkg::CMD_TTRST]),
    .res_sel(r.cfg2[hostreg_pkg::CFG2_RES_LO +: 3]),
    .us_tick(us_tick),
    .frame_tick(frame_tick),
    .ttag_tick(ttag_tick)
  );

  // Next-state logic for every register of the bank.
  always_comb begin
    n = r;
    n.swrst_p = 1'b0;
    n.bist_p = 1'b0;
    n.bclr_p = 1'b0;
    n.halt_p = 1'b0;
    n.fstart_p = 1'b0;
    n.trig_p = hit;
    n.tt_wr = 1'b0;

    // Plain host-writable registers.
    if (wr_at(hostreg_pkg::OFF_CFG1)) n.cfg1 = wd;
    if (wr_at(hostreg_pkg::OFF_CFG2)) n.cfg2 = wd;
    if (wr_at(hostreg_pkg::OFF_CFG3)) n.cfg3 = wd;
    if (wr_at(hostreg_pkg::OFF_CFG6)) n.cfg6 = wd;
    if (wr_at(hostreg_pkg::OFF_MASK1)) n.mask1 = wd;
    if (wr_at(hostreg_pkg::OFF_MASK2)) n.mask2 = wd;
    if (wr_at(hostreg_pkg::OFF_IILP)) n.iilp = wd;

    // Frame period write in controller mode.
    // Trigger word write in word monitor mode.
    if (wr_at(hostreg_pkg::OFF_FTIME) && (mode != hostreg_pkg::MODE_RT)) n.ftime = wd;
    if (eng.rtcmd_vld && (mode == hostreg_pkg::MODE_RT)) n.ftime = eng.rtcmd;

    if (eng.cstk_vld) n.cstk = eng.cstk;
    if (eng.ilp_vld) n.ilp = eng.ilp;
    if (eng.cw_vld) n.ctlw = eng.cw;

    // Host write, engine update wins a tie.
    if (wr_at(hostreg_pkg::OFF_DSTK)) n.dstk = wd;
    if (eng.dstk_vld) n.dstk = eng.dstk;

    if (wr_at(hostreg_pkg::OFF_GPQ)) n.gpq = wd;
    if (eng.gpq_inc) n.gpq = r.gpq + 16'h0001;
    // Status queue pointer load and advance.
    if (wr_at(hostreg_pkg::OFF_ISQ)) n.isq = wd;
    if (eng.isq_inc) n.isq = r.isq + 16'h0001;

    // Low byte sets, high byte clears, both toggles.
    if (wr_at(hostreg_pkg::OFF_GPFLAG)) begin
      n.gp = (r.gp & ~wd[hostreg_pkg::GP_CLR_LO +: 8]) | (wd[7:0] & ~r.gp);
      n.gp = n.gp | (wd[7:0] & ~wd[hostreg_pkg::GP_CLR_LO +: 8]);
    end

    // Time tag advance, reset and test increment.
    if (ttag_tick || cmd[hostreg_pkg::CMD_TTTEST]) n.ttag = r.ttag + 16'h0001;
    if (cmd[hostreg_pkg::CMD_TTRST]) n.ttag = '0;

    // Store time tag at message start and end, except in word monitor mode.
    if ((eng.start_of_message_event || eng.end_of_message_event) &&
        (mode != hostreg_pkg::MODE_WORDMON)) begin
      n.tt_wr = 1'b1;
      n.tt_val = r.ttag;
    end

    if (us_tick && (r.mrem != 16'h0000)) n.mrem = r.mrem - 16'(hostreg_pkg::MSG_LSB_US);
    if (eng.mrem_ld) n.mrem = eng.mrem;

    n.swrst_p = cmd[hostreg_pkg::CMD_SWRST];
    n.bist_p = cmd[hostreg_pkg::CMD_BIST];
    n.bclr_p = cmd[hostreg_pkg::CMD_BCLR];
    n.halt_p = cmd[hostreg_pkg::CMD_HALTCLR];

    // Frame countdown in 100 us steps.
    if (frame_tick && (r.bc != BC_IDLE) && !fend) n.frem = r.frem - 16'h0001;

    // Controller run state with both stop flavours.
    case (r.bc)
      BC_IDLE: begin
        if (cmd[hostreg_pkg::CMD_START] && (mode == hostreg_pkg::MODE_BC)) begin
          n.bc = BC_RUN;
          n.frem = r.ftime;
          n.fstart_p = 1'b1;
        end
      end
      BC_RUN: begin
        if (cmd[hostreg_pkg::CMD_STOPMSG]) n.bc = BC_STOP_MSG;
        else if (cmd[hostreg_pkg::CMD_STOPFRM]) n.bc = BC_STOP_FRM;
        if (fend) begin
          if (r.cfg1[hostreg_pkg::CFG1_AUTORPT]) begin
            n.frem = r.ftime;
            n.fstart_p = 1'b1;
          end else begin
            n.bc = BC_IDLE;
            n.frem = '0;
          end
        end
      end
      BC_STOP_MSG: begin
        if (eng.end_of_message_event || fend) begin
          n.bc = BC_IDLE;
          n.frem = '0;
        end
      end
      BC_STOP_FRM: begin
        if (fend) begin
          n.bc = BC_IDLE;
          n.frem = '0;
        end
      end
      default: n.bc = BC_IDLE;
    endcase

    // Monitor run control from start command and trigger.
    if (cmd[hostreg_pkg::CMD_START] && (mode != hostreg_pkg::MODE_BC)) n.mon = 1'b1;
    if (hit && r.cfg3[hostreg_pkg::CFG3_TRIG_START]) n.mon = 1'b1;
    if (hit && r.cfg3[hostreg_pkg::CFG3_TRIG_STOP]) n.mon = 1'b0;

    // Events latch at their mask bit position; set beats clear.
    if (cmd[hostreg_pkg::CMD_IRQRST] || cmd[hostreg_pkg::CMD_SWRST]) begin
      n.isr1 = '0;
      n.isr2 = '0;
    end
    n.isr1 = n.isr1 | (eng.isr1_ev & r.mask1);
    if (hit && r.cfg3[hostreg_pkg::CFG3_TRIG_IRQ] && r.mask1[hostreg_pkg::ISR1_TRIG]) begin
      n.isr1[hostreg_pkg::ISR1_TRIG] = 1'b1;
    end
    n.isr2 = n.isr2 | (eng.isr2_ev & r.mask2);
    // Chain flag follows any pending first-register event.
    n.isr2[hostreg_pkg::ISR2_CHAIN] = |n.isr1;

    // Software reset returns engine-facing state to idle.
    if (cmd[hostreg_pkg::CMD_SWRST]) begin
      n.bc = BC_IDLE;
      n.mon = 1'b0;
      n.frem = '0;
      n.mrem = '0;
      n.gp = '0;
    end

    // Read data captured in the setup cycle; unmapped reads flag an error.
    if (setup) begin
      n.prdata = '0;
      n.pslverr = 1'b0;
      case (apb_req.paddr)
        hostreg_pkg::OFF_CFG1: n.prdata[15:0] = r.cfg1;
        hostreg_pkg::OFF_CFG2: n.prdata[15:0] = r.cfg2;
        hostreg_pkg::OFF_CFG3: n.prdata[15:0] = r.cfg3;
        hostreg_pkg::OFF_CFG6: n.prdata[15:0] = r.cfg6;
        hostreg_pkg::OFF_START: n.prdata[15:0] = '0;
        hostreg_pkg::OFF_CSTK: n.prdata[15:0] = r.cstk;
        // Live pointer only in enhanced controller mode.
        hostreg_pkg::OFF_ILP: n.prdata[15:0] = r.cfg1[hostreg_pkg::CFG1_ENH_BC] ? r.ilp : '0;
        hostreg_pkg::OFF_CTLW: n.prdata[15:0] = r.ctlw;
        hostreg_pkg::OFF_TTAG: n.prdata[15:0] = r.ttag;
        hostreg_pkg::OFF_ISR1: n.prdata[15:0] = r.isr1;
        hostreg_pkg::OFF_ISR2: n.prdata[15:0] = r.isr2;
        hostreg_pkg::OFF_DSTK: n.prdata[15:0] = r.dstk;
        hostreg_pkg::OFF_FREM: n.prdata[15:0] = r.frem;
        hostreg_pkg::OFF_MREM: n.prdata[15:0] = r.mrem;
        hostreg_pkg::OFF_FTIME: n.prdata[15:0] = r.ftime;
        hostreg_pkg::OFF_IILP: n.prdata[15:0] = r.iilp;
        hostreg_pkg::OFF_CCODE: n.prdata[15:0] = {eng.cc_result, r.gp};
        hostreg_pkg::OFF_GPFLAG: n.prdata[15:0] = '0;
        hostreg_pkg::OFF_GPQ: n.prdata[15:0] = r.gpq;
        hostreg_pkg::OFF_ISQ: n.prdata[15:0] = r.isq;
        hostreg_pkg::OFF_MASK1: n.prdata[15:0] = r.mask1;
        hostreg_pkg::OFF_MASK2: n.prdata[15:0] = r.mask2;
        default: n.pslverr = 1'b1;
      endcase
    end
  end

  // State register; configuration clears except the enhanced access bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      // Enhanced access bit comes out of reset set.
      r.cfg6 <= hostreg_pkg::CFG6_RESET;
    end else begin
      r <= n;
    end
  end

  // Bus answer and engine controls.
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = r.pslverr && apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata = r.prdata;
  assign ctl.sw_reset = r.swrst_p;
  assign ctl.bist_start = r.bist_p;
  assign ctl.bist_clear = r.bclr_p;
  assign ctl.halt_clear = r.halt_p;
  assign ctl.frame_start = r.fstart_p;
  assign ctl.bc_running = (r.bc != BC_IDLE);
  assign ctl.mon_running = r.mon;
  assign ctl.trig_hit = r.trig_p;
  assign ctl.msg_timer_zero = (r.mrem == 16'h0000);
  assign ctl.ttag_wr = r.tt_wr;
  assign ctl.ttag_val = r.tt_val;
  assign ctl.cfg1 = r.cfg1;
  assign ctl.cfg2 = r.cfg2;
  assign ctl.cfg3 = r.cfg3;
  assign ctl.cfg6 = r.cfg6;
  assign ctl.init_ilp = r.iilp;
  assign ctl.gp_flags = r.gp;
  assign ctl.gpq = r.gpq;
  assign ctl.isq = r.isq;
  assign ctl.dstk = r.dstk;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Named sequences for command write and one-cycle reset pulse.
  sequence s_cmd(int b);
    wr && (apb_req.paddr == hostreg_pkg::OFF_START) && apb_req.pwdata[b];
  endsequence
  sequence s_pulse_once;
    ctl.sw_reset ##1 !ctl.sw_reset;
  endsequence

  // Reset command is a single pulse.
  chk_swrst_pulse: assert property (s_cmd(hostreg_pkg::CMD_SWRST) |=> s_pulse_once)
    else $error("software reset command not a one-cycle pulse");
  // Message stop ends run at message end.
  chk_stop_msg: assert property ((r.bc == BC_STOP_MSG) && eng.end_of_message_event
    && !wr |=> !ctl.bc_running)
    else $error("controller did not stop after message");
  chk_cstk_cap: assert property (eng.cstk_vld |=> r.cstk == $past(eng.cstk))
    else $error("command stack pointer not captured");
  // Time tag written at message start in controller mode.
  chk_ttag_store: assert property (eng.start_of_message_event && mode == hostreg_pkg::MODE_BC
    |=> ctl.ttag_wr && ctl.ttag_val == $past(r.ttag))
    else $error("time tag not stored at message start");
  // Chain flag tracks first status register.
  chk_chain_flag: assert property ((r.isr1 != 16'h0000) |-> r.isr2[hostreg_pkg::ISR2_CHAIN])
    else $error("chain flag missing with events pending");
  // Frame counter steps down by one per 100 us tick.
  chk_frame_step: assert property (frame_tick && r.bc == BC_RUN && r.frem > 16'h0001 && !wr
    && !eng.end_of_message_event |=> r.frem == $past(r.frem) - 16'h0001)
    else $error("frame remaining counter did not step");
  chk_cfg_reset: assert property (disable iff (1'b0) $past(rst) |-> r.cfg1 == 16'h0000
    && r.cfg6 == hostreg_pkg::CFG6_RESET)
    else $error("configuration reset value wrong");
  // Set and clear together toggle a flag.
  chk_gp_toggle: assert property (wr_at(hostreg_pkg::OFF_GPFLAG) && wd[0] && wd[8]
    && !wr_at(hostreg_pkg::OFF_START) |=> r.gp[0] != $past(r.gp[0]))
    else $error("general flag did not toggle");
  chk_gpq_inc: assert property (eng.gpq_inc |=> ctl.gpq == $past(r.gpq) + 16'h0001)
    else $error("queue pointer did not increment");
endmodule // terminal_host_register_bank

// File: verification/engine_model.sv
// Purpose: Stand-in for the protocol and sequencing engines behind the register bank.
// Assumes: Reports are one cycle wide and launched just after a rising edge.
// Notes: Between reports every strobe is low; condition flags stay as a level.
`timescale 1ns/1ps
module engine_model (
  // Clock.
  input wire logic clk,
  // Condition flags held as a level.
  input wire logic [7:0] cc,
  // Reports toward the register bank.
  output hostreg_pkg::eng_s eng
);
  hostreg_pkg::eng_s pulse;

  // Merges the current report with the standing condition flags.
  always_comb begin
    eng = pulse;
    eng.cc_result = cc;
  end

  // Starts idle so no strobe is seen before the first report.
  initial begin
    pulse = '0;
  end

  // Posts one report for a single cycle, then drops every strobe again.
  task automatic post(input hostreg_pkg::eng_s v);
    @(posedge clk);
    pulse <= v;
    @(posedge clk);
    pulse <= '0;
  endtask
endmodule // engine_model

// File: verification/tb_terminal_host_register_bank.sv
// Purpose: Self-checking bench for the terminal host register bank.
// Assumes: Reads are noted in a queue and compared when the access completes.
// Notes: A short microsecond divider keeps the run brief.
`timescale 1ns/1ps
module tb_terminal_host_register_bank;
  logic clk;
  logic rst;
  hostreg_pkg::apb_req_s req;
  hostreg_pkg::apb_rsp_s rsp;
  hostreg_pkg::eng_s eng;
  hostreg_pkg::ctl_s ctl;
  hostreg_pkg::eng_s e;
  logic [7:0] cc;
  logic [15:0] val;
  logic [31:0] exp_q[$];
  string name_q[$];
  int failures;
  int checked;
  logic [3:0] pulses;

  // Groups the one-shot command outputs for a single compare.
  assign pulses = {ctl.sw_reset, ctl.bist_start, ctl.bist_clear, ctl.halt_clear};

  // Device under test and the engine stand-in.
  terminal_host_register_bank #(.CYC_PER_US(8)) i_dut (.clk(clk), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .eng(eng), .ctl(ctl));
  engine_model i_eng (.clk(clk), .cc(cc), .eng(eng));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, want, seen);
    end
  endtask

  // One APB transfer; a read notes its expected word for the monitor.
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input string n);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= w ? {16'h0000, d} : 32'h0000_0000;
    if (!w) begin
      exp_q.push_back({16'h0000, d});
      name_q.push_back(n);
    end
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Takes the oldest noted read and compares it with the completed access.
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      check("pslverr", {31'h0, rsp.pslverr}, {31'h0, req.paddr > hostreg_pkg::OFF_CFG6});
    end
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), rsp.prdata, exp_q.pop_front());
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  // Main sequence of scenarios.
  initial begin
    rst = 1'b1;
    req = '0;
    cc = 8'h00;
    e = '0;
    failures = 0;
    checked = 0;
    val = 16'h0000;
    void'($urandom(82256));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, hostreg_pkg::OFF_CFG1, 16'h0000, "cfg1");
    apb(1'b0, hostreg_pkg::OFF_CFG6, 16'h0001, "cfg6");
    apb(1'b1, hostreg_pkg::OFF_CFG2, 16'h0001, "");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h00E1, "");
    #1 check("pulses", {28'h0, pulses}, 32'h0000_000F);
    @(posedge clk);
    #1 check("pulses", {28'h0, pulses}, 32'h0000_0000);
    // Data stack: host load, then engine overwrite.
    val = 16'($urandom());
    apb(1'b1, hostreg_pkg::OFF_DSTK, val, "");
    apb(1'b0, hostreg_pkg::OFF_DSTK, val, "dstk");
    e = '0;
    e.dstk_vld = 1'b1;
    e.dstk = ~val;
    i_eng.post(e);
    apb(1'b0, hostreg_pkg::OFF_DSTK, ~val, "dstk");
    #1 check("ctl_dstk", {16'h0, ctl.dstk}, {16'h0, ~val});
    // Queue pointers advance by engine pulses; the status queue wraps.
    apb(1'b1, hostreg_pkg::OFF_GPQ, 16'h0100, "");
    apb(1'b1, hostreg_pkg::OFF_ISQ, 16'hFFFF, "");
    e = '0;
    e.gpq_inc = 1'b1;
    e.isq_inc = 1'b1;
    i_eng.post(e);
    i_eng.post(e);
    apb(1'b0, hostreg_pkg::OFF_GPQ, 16'h0102, "gpq");
    apb(1'b0, hostreg_pkg::OFF_ISQ, 16'h0001, "isq");
    #1 check("queues", {ctl.gpq, ctl.isq}, 32'h0102_0001);
    // Flags: set, clear, toggle, then read with the result flags.
    cc <= 8'($urandom());
    apb(1'b1, hostreg_pkg::OFF_GPFLAG, 16'h00F0, "");
    apb(1'b1, hostreg_pkg::OFF_GPFLAG, 16'h3000, "");
    apb(1'b1, hostreg_pkg::OFF_GPFLAG, 16'h0303, "");
    apb(1'b0, hostreg_pkg::OFF_CCODE, {cc, 8'hC3}, "ccode");
    #1 check("gp_flags", {24'h0, ctl.gp_flags}, 32'h0000_00C3);
    // A masked event lands at its mask position and sets the chain flag.
    apb(1'b1, hostreg_pkg::OFF_MASK1, 16'hFFFF, "");
    e = '0;
    e.isr1_ev = 16'h0008;
    i_eng.post(e);
    apb(1'b0, hostreg_pkg::OFF_ISR1, 16'h0008, "isr1");
    apb(1'b0, hostreg_pkg::OFF_ISR2, 16'h8000, "isr2");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0004, "");
    apb(1'b0, hostreg_pkg::OFF_ISR1, 16'h0000, "isr1");
    // Enhanced controller pointers and mirrored words.
    apb(1'b1, hostreg_pkg::OFF_IILP, 16'h0040, "");
    #1 check("init_ilp", {16'h0, ctl.init_ilp}, 32'h0000_0040);
    apb(1'b1, hostreg_pkg::OFF_CFG1, 16'h0004, "");
    e = '0;
    e.ilp_vld = 1'b1;
    e.ilp = 16'h0046;
    e.cstk_vld = 1'b1;
    e.cstk = 16'h0118;
    e.cw_vld = 1'b1;
    e.cw = val;
    i_eng.post(e);
    apb(1'b0, hostreg_pkg::OFF_ILP, 16'h0046, "ilp");
    apb(1'b0, hostreg_pkg::OFF_CSTK, 16'h0118, "cstk");
    apb(1'b0, hostreg_pkg::OFF_CTLW, val, "ctlw");
    apb(1'b1, hostreg_pkg::OFF_FTIME, 16'h1234, "");
    apb(1'b0, hostreg_pkg::OFF_FTIME, 16'h1234, "ftime");
    // Terminal mode: shared register takes the command word, not host data.
    apb(1'b1, hostreg_pkg::OFF_CFG1, 16'h0001, "");
    e = '0;
    e.rtcmd_vld = 1'b1;
    e.rtcmd = 16'hA5C3;
    i_eng.post(e);
    apb(1'b1, hostreg_pkg::OFF_FTIME, 16'h0F0F, "");
    apb(1'b0, hostreg_pkg::OFF_FTIME, 16'hA5C3, "ftime");
    apb(1'b0, 8'hFC, 16'h0000, "unmapped");
    // Controller: auto-repeat keeps running until a stop after frame.
    apb(1'b1, hostreg_pkg::OFF_CFG1, 16'h0008, "");
    apb(1'b1, hostreg_pkg::OFF_FTIME, 16'h0002, "");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0002, "");
    #1 check("bc_start", {30'h0, ctl.frame_start, ctl.bc_running}, 32'h3);
    repeat (2000) @(posedge clk);
    #1 check("bc_running", {31'h0, ctl.bc_running}, 32'h1);
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0200, "");
    #1 check("bc_running", {31'h0, ctl.bc_running}, 32'h1);
    repeat (1700) @(posedge clk);
    #1 check("bc_running", {31'h0, ctl.bc_running}, 32'h0);
    apb(1'b0, hostreg_pkg::OFF_FREM, 16'h0000, "frem");
    // Controller: stop after the message in progress.
    apb(1'b1, hostreg_pkg::OFF_FTIME, 16'h0100, "");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0002, "");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0100, "");
    #1 check("bc_running", {31'h0, ctl.bc_running}, 32'h1);
    e = '0;
    e.end_of_message_event = 1'b1;
    i_eng.post(e);
    #1 check("bc_running", {31'h0, ctl.bc_running}, 32'h0);
    // Time tag at 64 us per count, stored at message start; message timer runs out.
    apb(1'b1, hostreg_pkg::OFF_CFG2, 16'h000B, "");
    #1 check("cfg", {ctl.cfg6, ctl.cfg2}, 32'h0001_000B);
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0008, "");
    apb(1'b1, hostreg_pkg::OFF_START, 16'h0010, "");
    e = '0;
    e.start_of_message_event = 1'b1;
    e.mrem_ld = 1'b1;
    e.mrem = 16'h0003;
    i_eng.post(e);
    #1 check("ttag_store", {15'h0, ctl.ttag_wr, ctl.ttag_val}, 32'h0001_0001);
    check("msg_zero", {31'h0, ctl.msg_timer_zero}, 32'h0);
    repeat (600) @(posedge clk);
    #1 check("msg_zero", {31'h0, ctl.msg_timer_zero}, 32'h1);
    apb(1'b0, hostreg_pkg::OFF_TTAG, 16'h0002, "ttag");
    // Word monitor: the trigger word starts, then stops, the monitor.
    apb(1'b1, hostreg_pkg::OFF_CFG1, 16'h0003, "");
    apb(1'b1, hostreg_pkg::OFF_FTIME, 16'h5A5A, "");
    apb(1'b1, hostreg_pkg::OFF_CFG3, 16'h0001, "");
    #1 check("cfg", {ctl.cfg1, ctl.cfg3}, 32'h0003_0001);
    e = '0;
    e.mword_vld = 1'b1;
    e.mword = 16'h5A5A;
    i_eng.post(e);
    #1 check("trigger", {30'h0, ctl.trig_hit, ctl.mon_running}, 32'h3);
    apb(1'b1, hostreg_pkg::OFF_CFG3, 16'h0002, "");
    i_eng.post(e);
    #1 check("trigger", {30'h0, ctl.trig_hit, ctl.mon_running}, 32'h2);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule // tb_terminal_host_register_bank
